/* design/temp_alarm_pkg.sv */
// temp_alarm_pkg: command codes, reset values, bus states and state carrier
// for the temperature alarm and command register block.
// assumes a 50 MHz mclk and an SMBus host on the two bus pins.
package temp_alarm_pkg;
  localparam logic [7:0] CMD_LOCAL_TEMP   = 8'h00;
  localparam logic [7:0] CMD_REMOTE_TEMP  = 8'h01;
  localparam logic [7:0] CMD_STATUS       = 8'h02;
  localparam logic [7:0] CMD_CONFIG_RD    = 8'h03;
  localparam logic [7:0] CMD_RATE_RD      = 8'h04;
  localparam logic [7:0] CMD_LOC_UP_RD    = 8'h05;
  localparam logic [7:0] CMD_LOC_LO_RD    = 8'h06;
  localparam logic [7:0] CMD_REM_UP_RD    = 8'h07;
  localparam logic [7:0] CMD_REM_LO_RD    = 8'h08;
  localparam logic [7:0] CMD_CONFIG_WR    = 8'h09;
  localparam logic [7:0] CMD_RATE_WR      = 8'h0A;
  localparam logic [7:0] CMD_LOC_UP_WR    = 8'h0B;
  localparam logic [7:0] CMD_LOC_LO_WR    = 8'h0C;
  localparam logic [7:0] CMD_REM_UP_WR    = 8'h0D;
  localparam logic [7:0] CMD_REM_LO_WR    = 8'h0E;
  localparam logic [7:0] CMD_SINGLE_CONV  = 8'h0F;
  localparam logic [7:0] CMD_REM_FRAC     = 8'h10;
  localparam logic [7:0] CMD_LOC_FRAC     = 8'h11;
  localparam logic [7:0] CMD_REM_TRIP_B   = 8'h16;
  localparam logic [7:0] CMD_LOC_TRIP_B   = 8'h17;
  localparam logic [7:0] CMD_REM_TRIP_A   = 8'h19;
  localparam logic [7:0] CMD_LOC_TRIP_A   = 8'h20;
  localparam logic [7:0] CMD_MARGIN       = 8'h21;
  localparam logic [7:0] CMD_MAKER_CODE   = 8'hFE;
  localparam logic [7:0] RST_POINTER      = 8'h00;
  localparam logic [7:0] RST_CONFIG       = 8'h20;
  localparam logic [7:0] RST_RATE         = 8'h08;
  localparam logic [7:0] RST_UPPER        = 8'h46;
  localparam logic [7:0] RST_LOWER        = 8'hC9;
  localparam logic [7:0] RST_TRIP         = 8'h55;
  localparam logic [7:0] RST_MARGIN       = 8'h0A;
  localparam logic [7:0] CONFIG_WR_MASK   = 8'hE0;
  localparam int         CFG_MASK_BIT     = 7;
  localparam int         CFG_STANDBY_BIT  = 6;
  localparam int         CFG_SUBSTR_BIT   = 5;
  localparam logic [3:0] FASTEST_RATE     = 4'h8;
  localparam logic [6:0] OWN_ADDR         = 7'h4C;
  localparam logic [6:0] ALERT_RESP_ADDR  = 7'h0C;
  // arbitrary value, not a real maker code
  localparam logic [7:0] MAKER_CODE       = 8'hA5;
  localparam int         CLK_MHZ          = 50;
  localparam int         FAST_INTERVAL_US = 62500;
  localparam int         FAST_INTERVAL_CYC = FAST_INTERVAL_US * CLK_MHZ;

  typedef enum logic [5:0] {
    BUS_IDLE   = 6'h01,
    BUS_ADDR   = 6'h02,
    BUS_ACK    = 6'h04,
    BUS_RX     = 6'h08,
    BUS_TX     = 6'h10,
    BUS_TX_ACK = 6'h20
  } bus_state_e;

  typedef struct packed {
    logic [7:0] localTemp;
    logic [7:0] remoteTemp;
    logic [2:0] localFrac;
    logic [2:0] remoteFrac;
    logic       openFault;
  } conv_result_s;

  typedef struct packed {
    logic [1:0]      sclSync;
    logic [1:0]      sdaSync;
    logic            sclPrev;
    logic            sdaPrev;
    bus_state_e      bus;
    logic [2:0]      bitCnt;
    logic [7:0]      shift;
    logic            isRead;
    logic            isAra;
    logic            gotCmd;
    logic            ackOn;
    logic            sdaOeN;
    logic [7:0]      pointer;
    logic [7:0]      cfgByte;
    logic [7:0]      rate;
    logic [1:0][7:0] upperLim;
    logic [1:0][7:0] lowerLim;
    logic [1:0][7:0] tripALim;
    logic [1:0][7:0] tripBLim;
    logic [7:0]      margin;
    conv_result_s    result;
    logic            busy;
    logic            needStart;
    logic            convStart;
    logic [31:0]     timer;
    logic [4:0]      alarmFlags;
    logic            alarmLatch;
    logic            alarmOeN;
    logic [1:0]      tripA;
    logic [1:0]      tripB;
    logic            tripAOut;
    logic            tripBOut;
    logic            pinLow;
  } dev_state_s;
endpackage : temp_alarm_pkg

/* design/temp_alarm_regs.sv */
// temp_alarm_regs: SMBus slave, command registers, conversion scheduling,
// alarm latch and thermal trip outputs of the two-channel sensor.
// assumes the converter shares mclk and pulses convDone with a result.
`timescale 1ns/1ps
// Overview of operation
// - alarm when reading hits upper or lower limit
// - alarm limits reset to +70 and -55
// - open remote junction also raises alarm
// - alarm latched; status read or ARA clears
// - clear works; persisting cause resets next conversion
// - alarm set at most once per conversion
// - alarm output is open-drain, low when active
// - pending device answers ARA with arbitration
// - completed alert response clears the latch
// - trip asserts at limit; limits reset +85
// - trip holds until below limit minus margin
// - one shared margin register at 21h
// - command pointer resets to zero
// - configuration read 03h, write 09h, reset 20h
// - config bits: mask, standby, junction type
// - rate read 04h, write 0Ah, reset 08h
// - fractions at 10h and 11h, top bits
// - trip limits at 19h, 20h, 16h, 17h
// - single conversion command starts conversion now
// - single conversion ignored while busy
// - single conversion restarts the interval timer
module temp_alarm_regs #(
  parameter int unsigned INTERVAL_CYCLES = temp_alarm_pkg::FAST_INTERVAL_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         reset,
  input  wire logic                         clkEn,
  input  wire logic                         sclIn,
  input  wire logic                         sdaIn,
  output logic                              sdaOut,
  output logic                              sdaOeN,
  output logic                              alarmOut,
  output logic                              alarmOeN,
  output logic                              tripAOut,
  output logic                              tripBOut,
  output logic                              substrateSel,
  output logic                              convStart,
  input  wire logic                         convDone,
  input  wire temp_alarm_pkg::conv_result_s convResult
);
  import temp_alarm_pkg::*;

  dev_state_s      st;
  dev_state_s      next_st;
  logic [1:0][7:0] newTemp;
  logic [1:0]      hiHit;
  logic [1:0]      loHit;
  logic [1:0]      nextTripA;
  logic [1:0]      nextTripB;
  logic            sclRise;
  logic            sclFall;
  logic            busStart;
  logic            busStop;
  logic [7:0]      rxByte;
  logic [31:0]     loadVal;
  logic [3:0]      shiftAmt;
  logic            alarmClr;
  logic            oneShotCmd;
  logic            doneEv;
  logic            doneTaken;

  assign newTemp = {convResult.remoteTemp, convResult.localTemp};
  assign doneEv  = convDone & st.busy;
  assign doneTaken = doneEv & clkEn;

  // per channel: index 0 local, 1 remote
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic signed [8:0] tempS;
    logic signed [8:0] relA;
    logic signed [8:0] relB;
    assign tempS = 9'($signed(newTemp[c]));
    assign relA  = 9'($signed(st.tripALim[c])) - 9'($signed(st.margin));
    assign relB  = 9'($signed(st.tripBLim[c])) - 9'($signed(st.margin));
    assign hiHit[c] = tempS >= 9'($signed(st.upperLim[c]));
    assign loHit[c] = tempS <= 9'($signed(st.lowerLim[c]));
    // set at limit, release only below limit minus margin
    assign nextTripA[c] = (tempS >= 9'($signed(st.tripALim[c])))
                        | (st.tripA[c] & ~(tempS < relA));
    assign nextTripB[c] = (tempS >= 9'($signed(st.tripBLim[c])))
                        | (st.tripB[c] & ~(tempS < relB));
  end

  assign sclRise  = st.sclSync[1] & ~st.sclPrev;
  assign sclFall  = ~st.sclSync[1] & st.sclPrev;
  assign busStart = st.sclSync[1] & st.sclPrev & st.sdaPrev & ~st.sdaSync[1];
  assign busStop  = st.sclSync[1] & st.sclPrev & ~st.sdaPrev & st.sdaSync[1];
  assign rxByte   = {st.shift[6:0], st.sdaSync[1]};
  assign shiftAmt = (st.rate[3:0] >= FASTEST_RATE) ? 4'h0 : FASTEST_RATE - st.rate[3:0];
  assign loadVal  = INTERVAL_CYCLES << shiftAmt;

  function automatic logic [7:0] readReg(input dev_state_s s);
    case (s.pointer)
      CMD_LOCAL_TEMP:  readReg = s.result.localTemp;
      CMD_REMOTE_TEMP: readReg = s.result.remoteTemp;
      CMD_STATUS:      readReg = {s.busy, s.alarmFlags, s.tripA[1], s.tripA[0]};
      CMD_CONFIG_RD:   readReg = s.cfgByte;
      CMD_RATE_RD:     readReg = s.rate;
      CMD_LOC_UP_RD:   readReg = s.upperLim[0];
      CMD_LOC_LO_RD:   readReg = s.lowerLim[0];
      CMD_REM_UP_RD:   readReg = s.upperLim[1];
      CMD_REM_LO_RD:   readReg = s.lowerLim[1];
      CMD_REM_FRAC:    readReg = {s.result.remoteFrac, 5'h00};
      CMD_LOC_FRAC:    readReg = {s.result.localFrac, 5'h00};
      CMD_REM_TRIP_B:  readReg = s.tripBLim[1];
      CMD_LOC_TRIP_B:  readReg = s.tripBLim[0];
      CMD_REM_TRIP_A:  readReg = s.tripALim[1];
      CMD_LOC_TRIP_A:  readReg = s.tripALim[0];
      CMD_MARGIN:      readReg = s.margin;
      CMD_MAKER_CODE:  readReg = MAKER_CODE;
      default:         readReg = 8'h00;
    endcase
  endfunction : readReg

  always_comb begin
    logic statusClr;
    logic araClr;
    logic startReq;
    statusClr  = 1'b0;
    araClr     = 1'b0;
    oneShotCmd = 1'b0;
    startReq   = 1'b0;
    next_st    = st;
    next_st.sclSync = {st.sclSync[0], sclIn};
    next_st.sdaSync = {st.sdaSync[0], sdaIn};
    next_st.sclPrev = st.sclSync[1];
    next_st.sdaPrev = st.sdaSync[1];
    next_st.convStart = 1'b0;

    if (busStart) begin
      next_st.bus    = BUS_ADDR;
      next_st.bitCnt = 3'h0;
      next_st.gotCmd = 1'b0;
      next_st.ackOn  = 1'b0;
      next_st.sdaOeN = 1'b1;
    end else if (busStop) begin
      next_st.bus    = BUS_IDLE;
      next_st.sdaOeN = 1'b1;
    end else begin
      case (st.bus)
        BUS_IDLE: begin
          next_st.sdaOeN = 1'b1;
        end
        BUS_ADDR: begin
          if (sclRise) begin
            next_st.shift  = rxByte;
            next_st.bitCnt = st.bitCnt + 3'h1;
            if (st.bitCnt == 3'h7) begin
              next_st.isRead = rxByte[0];
              next_st.isAra  = 1'b0;
              next_st.bus    = BUS_ACK;
              if (rxByte[7:1] == OWN_ADDR) begin
                next_st.shift = readReg(st);
              end else if (rxByte[7:1] == ALERT_RESP_ADDR && rxByte[0] && !st.alarmOeN) begin
                next_st.isAra = 1'b1;
                next_st.shift = {OWN_ADDR, 1'b0};
              end else begin
                next_st.bus = BUS_IDLE;
              end
            end
          end
        end
        BUS_ACK: begin
          if (sclFall) begin
            next_st.bitCnt = 3'h0;
            if (!st.ackOn) begin
              next_st.sdaOeN = 1'b0;
              next_st.ackOn  = 1'b1;
            end else begin
              next_st.ackOn = 1'b0;
              if (st.isRead) begin
                next_st.sdaOeN = st.shift[7];
                next_st.shift  = {st.shift[6:0], 1'b0};
                next_st.bus    = BUS_TX;
              end else begin
                next_st.sdaOeN = 1'b1;
                next_st.bus    = BUS_RX;
              end
            end
          end
        end
        BUS_RX: begin
          if (sclRise) begin
            next_st.shift  = rxByte;
            next_st.bitCnt = st.bitCnt + 3'h1;
            if (st.bitCnt == 3'h7) begin
              next_st.bus = BUS_ACK;
              if (!st.gotCmd) begin
                next_st.gotCmd  = 1'b1;
                next_st.pointer = rxByte;
                oneShotCmd      = (rxByte == CMD_SINGLE_CONV);
              end else begin
                case (st.pointer)
                  CMD_CONFIG_WR:  next_st.cfgByte     = rxByte & CONFIG_WR_MASK;
                  CMD_RATE_WR:    next_st.rate        = rxByte;
                  CMD_LOC_UP_WR:  next_st.upperLim[0] = rxByte;
                  CMD_LOC_LO_WR:  next_st.lowerLim[0] = rxByte;
                  CMD_REM_UP_WR:  next_st.upperLim[1] = rxByte;
                  CMD_REM_LO_WR:  next_st.lowerLim[1] = rxByte;
                  CMD_REM_TRIP_B: next_st.tripBLim[1] = rxByte;
                  CMD_LOC_TRIP_B: next_st.tripBLim[0] = rxByte;
                  CMD_REM_TRIP_A: next_st.tripALim[1] = rxByte;
                  CMD_LOC_TRIP_A: next_st.tripALim[0] = rxByte;
                  CMD_MARGIN:     next_st.margin      = rxByte;
                  default:        next_st.margin      = st.margin;
                endcase
              end
            end
          end
        end
        BUS_TX: begin
          if (sclRise) begin
            next_st.bitCnt = st.bitCnt + 3'h1;
            if (st.bitCnt == 3'h7) begin
              next_st.bus = BUS_TX_ACK;
            end
            // released a one but the line reads zero: lost, no clear
            if (st.isAra && st.sdaOeN && !st.sdaSync[1]) begin
              next_st.bus    = BUS_IDLE;
              next_st.sdaOeN = 1'b1;
            end
          end else if (sclFall) begin
            next_st.sdaOeN = st.shift[7];
            next_st.shift  = {st.shift[6:0], 1'b0};
          end
        end
        BUS_TX_ACK: begin
          if (sclFall) begin
            next_st.sdaOeN = 1'b1;
          end else if (sclRise) begin
            next_st.bus = BUS_IDLE;
            araClr      = st.isAra;
            statusClr   = !st.isAra && st.pointer == CMD_STATUS;
          end
        end
        default: begin
          next_st.bus    = BUS_IDLE;
          next_st.sdaOeN = 1'b1;
        end
      endcase
    end

    // conversion scheduling
    if (doneEv) begin
      next_st.busy   = 1'b0;
      next_st.result = convResult;
    end
    if (st.needStart) begin
      startReq = 1'b1;
    end else if (oneShotCmd && !st.busy) begin
      startReq = 1'b1;
    end else if (!st.busy && !st.cfgByte[CFG_STANDBY_BIT] && st.timer == 32'h0) begin
      startReq = 1'b1;
    end
    if (startReq) begin
      next_st.convStart = 1'b1;
      next_st.busy      = 1'b1;
      next_st.needStart = 1'b0;
      next_st.timer     = loadVal - 32'h1;
    end else if (st.timer != 32'h0) begin
      next_st.timer = st.timer - 32'h1;
    end

    // alarm flags and latch: a new conversion wins over a clear
    alarmClr = statusClr | araClr;
    next_st.alarmFlags = st.alarmFlags & {5{~statusClr}};
    next_st.alarmLatch = st.alarmLatch & ~alarmClr;
    if (doneEv) begin
      next_st.alarmFlags = next_st.alarmFlags
                         | {hiHit[0], loHit[0], hiHit[1], loHit[1], convResult.openFault};
      if ((|hiHit) || (|loHit) || convResult.openFault) begin
        next_st.alarmLatch = 1'b1;
      end
      next_st.tripA = nextTripA;
      next_st.tripB = nextTripB;
    end
    next_st.alarmOeN = ~(next_st.alarmLatch & ~next_st.cfgByte[CFG_MASK_BIT]);
    next_st.tripAOut = |next_st.tripA;
    next_st.tripBOut = |next_st.tripB;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st            <= '0;
      st.bus        <= BUS_IDLE;
      st.sdaOeN     <= 1'b1;
      st.sclSync    <= 2'h3;
      st.sdaSync    <= 2'h3;
      st.sclPrev    <= 1'b1;
      st.sdaPrev    <= 1'b1;
      st.pointer    <= RST_POINTER;
      st.cfgByte    <= RST_CONFIG;
      st.rate       <= RST_RATE;
      st.upperLim   <= {RST_UPPER, RST_UPPER};
      st.lowerLim   <= {RST_LOWER, RST_LOWER};
      st.tripALim   <= {RST_TRIP, RST_TRIP};
      st.tripBLim   <= {RST_TRIP, RST_TRIP};
      st.margin     <= RST_MARGIN;
      st.busy       <= 1'b1;
      st.needStart  <= 1'b1;
      st.alarmOeN   <= 1'b1;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign sdaOut       = st.pinLow;
  assign sdaOeN       = st.sdaOeN;
  assign alarmOut     = st.pinLow;
  assign alarmOeN     = st.alarmOeN;
  assign tripAOut     = st.tripAOut;
  assign tripBOut     = st.tripBOut;
  assign substrateSel = st.cfgByte[CFG_SUBSTR_BIT];
  assign convStart    = st.convStart;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_accepted_shot;
    oneShotCmd && !st.busy && !st.needStart && clkEn;
  endsequence
  sequence s_conv_begins;
    st.convStart && st.busy ##1 !st.convStart;
  endsequence

  a_alarm_high_set: assert property (doneEv && clkEn && hiHit[0] |=> st.alarmLatch)
    else $error("local upper hit did not latch alarm");
  a_limit_reset_val: assert property ($fell(reset) |-> st.upperLim[1] == RST_UPPER
      && st.lowerLim[0] == RST_LOWER && st.pointer == RST_POINTER)
    else $error("limit or pointer reset value wrong");
  a_open_alarm_set: assert property (doneEv && clkEn && convResult.openFault
      |=> st.alarmLatch && st.alarmFlags[0])
    else $error("open junction did not raise alarm");
  a_latch_hold: assert property (st.alarmLatch && !(alarmClr && clkEn) |=> st.alarmLatch)
    else $error("alarm latch dropped without clear");
  a_clear_takes: assert property (alarmClr && clkEn && !doneEv |=> !st.alarmLatch)
    else $error("alarm clear had no effect");
  a_once_per_conv: assert property ($rose(st.alarmLatch) |-> $past(doneTaken))
    else $error("alarm set without a finished conversion");
  a_alarm_pin: assert property ($rose(st.alarmLatch) && !st.cfgByte[CFG_MASK_BIT]
      |-> !st.alarmOeN && !alarmOut)
    else $error("alarm pin not pulled low");
  a_trip_set: assert property (doneEv && clkEn
      && $signed(newTemp[1]) >= $signed(st.tripALim[1]) |=> st.tripAOut)
    else $error("remote trip did not assert");
  a_trip_hold: assert property (st.tripA[0] && !doneEv |=> st.tripA[0])
    else $error("trip released between conversions");
  a_shot_starts: assert property (s_accepted_shot |=> s_conv_begins)
    else $error("single conversion did not start");
  a_shot_ignored: assert property (oneShotCmd && st.busy && clkEn |=> !st.convStart)
    else $error("single conversion accepted while busy");
  a_shot_timer: assert property (s_accepted_shot |=> st.timer == loadVal - 32'h1)
    else $error("interval timer not restarted");
endmodule : temp_alarm_regs

/* dv/smbus_host.sv */
// smbus_host: behavioural SMBus host master on a 160 ns bus clock
// assumes the bench resolves the pulled-up data wire into sda
// each transfer starts just after a rising edge of clk, so bus edges stay off the clock edges
`timescale 1ns/1ps
module smbus_host (
  input  wire logic clk,
  output logic      scl,
  output logic      sdaDrv,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // data moves in the low phase, sampled late in the high phase
  task automatic bitx(input logic b, output logic s);
    #20 sdaDrv = b;
    #60 scl = 1'b1;
    #70 s = sda;
    #10 scl = 1'b0;
  endtask : bitx
  // start when b is 0, stop when b is 1; scl stands high after a stop
  task automatic cond(input logic b);
    #20 sdaDrv = ~b;
    #60 scl = 1'b1;
    #40 sdaDrv = b;
    #40 scl = b;
  endtask : cond
  task automatic byteOut(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(v[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : byteOut
  // nw command or data bytes, then an optional one-byte read closed by a nack
  task automatic xfer(input logic [6:0] adr, input logic rd, input int nw, input logic [15:0] w,
                      output logic [7:0] d, output logic ack);
    logic a;
    d = 8'hFF;
    @(posedge clk);
    #2 cond(1'b0);
    if (nw > 0) begin
      byteOut({adr, 1'b0}, ack);
      for (int i = 0; i < nw; i++) byteOut(i == 0 ? w[15:8] : w[7:0], a);
      if (rd) cond(1'b0);
    end
    if (rd) begin
      // a read with no command byte is a Receive Byte, also the alert response query
      byteOut({adr, 1'b1}, ack);
      if (ack) begin
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(1'b1, a);
      end
    end
    cond(1'b1);
  endtask : xfer
endmodule : smbus_host

/* dv/tb_top.sv */
// tb_top: self-checking bench for temp_alarm_regs with a host model and a converter stand-in
// assumes a 50 MHz mclk and a shortened 200-cycle conversion interval
`timescale 1ns/1ps
module tb_top;
  import temp_alarm_pkg::*;
  localparam int          IVL = 200;
  localparam logic [15:0] REGS [13] = '{16'h0320, 16'h0408, 16'h0546, 16'h06C9, 16'h0746, 16'h08C9,
    16'h1655, 16'h1755, 16'h1955, 16'h2055, 16'h210A, {CMD_MAKER_CODE, MAKER_CODE}, 16'h3000};
  logic         mclk, reset, sclIn, sdaDrv, sdaOut, sdaOeN, alarmOut, alarmOeN, ack, lat;
  logic         tripAOut, tripBOut, substrateSel, convStart, convDone;
  logic [1:0]   tA, tB;
  logic [7:0]   d, cfg, mg;
  logic [31:0]  r;
  wire logic    sdaIn;
  conv_result_s convResult, res;
  int           seed, cyc, miscompares, n_checks, nStart, nDone, n0, gap, dly;
  time          lastT;
  assign sdaIn = sdaDrv & (sdaOeN | sdaOut);
  temp_alarm_regs #(.INTERVAL_CYCLES(IVL)) DUT (.mclk(mclk), .reset(reset), .clkEn(1'b1), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .alarmOut(alarmOut), .alarmOeN(alarmOeN),
    .tripAOut(tripAOut), .tripBOut(tripBOut), .substrateSel(substrateSel), .convStart(convStart),
    .convDone(convDone), .convResult(convResult));
  smbus_host host (.clk(mclk), .scl(sclIn), .sdaDrv(sdaDrv), .sda(sdaIn));
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict;
    end
  end
  // converter stand-in: answers each start after dly cycles with res
  initial begin
    convDone = 1'b0;
    convResult = '0;
    forever begin
      @(posedge mclk);
      if (convStart === 1'b1) begin
        nStart++;
        gap = int'(($time - lastT) / 20);
        lastT = $time;
        repeat (dly) @(posedge mclk);
        #2 convDone = 1'b1;
        convResult = res;
        @(posedge mclk);
        #2 convDone = 1'b0;
        nDone++;
      end
    end
  end
  function automatic logic trip(input logic old, input logic [7:0] t, input logic [7:0] lim);
    if ($signed(t) >= $signed(lim)) return 1'b1;
    if ($signed({t[7], t}) < $signed({lim[7], lim}) - $signed({mg[7], mg})) return 1'b0;
    return old;
  endfunction : trip
  function automatic logic hit(input logic [7:0] t);
    return $signed(t) >= $signed(RST_UPPER) || $signed(t) <= $signed(RST_LOWER);
  endfunction : hit
  task automatic model;
    tA = {trip(tA[1], res.remoteTemp, RST_TRIP), trip(tA[0], res.localTemp, RST_TRIP)};
    tB = {trip(tB[1], res.remoteTemp, RST_TRIP), trip(tB[0], res.localTemp, 8'h50)};
    lat = lat | hit(res.localTemp) | hit(res.remoteTemp) | res.openFault;
  endtask : model
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    host.xfer(OWN_ADDR, 1'b0, 2, {c, v}, d, ack);
    chk("wrAck", 1'b1, ack);
  endtask : wr
  task automatic rd(input logic [7:0] c);
    host.xfer(OWN_ADDR, 1'b1, 1, {c, 8'h00}, d, ack);
  endtask : rd
  task automatic conv;
    int k;
    k = nDone;
    host.xfer(OWN_ADDR, 1'b0, 1, {CMD_SINGLE_CONV, 8'h00}, d, ack);
    for (int i = 0; i < 2000 && nDone == k; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    model;
  endtask : conv
  task automatic waitN;
    for (int i = 0; i < 3000 && nStart == n0; i++) @(posedge mclk);
    n0 = nStart;
  endtask : waitN
  initial begin
    seed = 32'h429A5150;
    reset = 1'b1;
    res = '0;
    dly = 50;
    {tA, tB, lat} = '0;
    mg = RST_MARGIN;
    repeat (2) @(posedge mclk);
    #2 reset = 1'b0;
    host.xfer(OWN_ADDR, 1'b1, 0, 16'h0, d, ack);
    chk("recvByte", 8'h00, d);
    chk("substrate", 1'b1, substrateSel);
    wr(CMD_LOC_UP_RD, 8'h11);
    for (int i = 0; i < 13; i++) begin
      rd(REGS[i][15:8]);
      chk("resetVal", REGS[i][7:0], d);
    end
    r = $random(seed);
    cfg = {2'b01, r[5:0]};
    mg = {4'h0, r[9:6]} + 8'h01;
    wr(CMD_CONFIG_WR, cfg);
    wr(CMD_LOC_TRIP_B, 8'h50);
    wr(CMD_MARGIN, mg);
    rd(CMD_CONFIG_RD);
    chk("config", cfg & CONFIG_WR_MASK, d);
    chk("substrate", cfg[5], substrateSel);
    rd(CMD_MARGIN);
    chk("margin", mg, d);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      res = '{8'h40 + 8'(r[4:0]), 8'h40 + 8'(r[9:5]), r[12:10], r[15:13], i == 5};
      if (i == 0) res.localTemp = RST_TRIP;
      if (i == 3) res.localTemp = 8'hC0;
      conv;
      chk("tripA", |tA, tripAOut);
      chk("tripB", |tB, tripBOut);
      chk("alarmN", !lat, alarmOeN);
      chk("alarmOut", 1'b0, alarmOut);
      rd(i[0] ? CMD_REM_FRAC : CMD_LOC_FRAC);
      chk("frac", {i[0] ? res.remoteFrac : res.localFrac, 5'h00}, d);
      rd(CMD_REMOTE_TEMP);
      chk("remTemp", res.remoteTemp, d);
      if (i[0]) begin
        host.xfer(ALERT_RESP_ADDR, 1'b1, 0, 16'h0, d, ack);
        chk("araAck", lat, ack);
        if (lat) chk("araAddr", {OWN_ADDR, 1'b0}, d);
      end else begin
        rd(CMD_STATUS);
        chk("statusTrip", tA, d[1:0]);
      end
      lat = 1'b0;
      chk("cleared", 1'b1, alarmOeN);
    end
    // a second single conversion while busy must not start another
    dly = 600;
    n0 = nStart;
    host.xfer(OWN_ADDR, 1'b0, 1, {CMD_SINGLE_CONV, 8'h00}, d, ack);
    conv;
    repeat (3 * IVL) @(posedge mclk);
    chk("starts", n0 + 1, nStart);
    dly = 50;
    res.localTemp = 8'h60;
    wr(CMD_CONFIG_WR, cfg | 8'h80);
    conv;
    chk("masked", 1'b1, alarmOeN);
    rd(CMD_STATUS);
    res = '0;
    wr(CMD_CONFIG_WR, cfg & 8'h20);
    n0 = nStart;
    waitN;
    host.xfer(OWN_ADDR, 1'b0, 1, {CMD_SINGLE_CONV, 8'h00}, d, ack);
    waitN;
    chk("oneShotEarly", 1'b1, gap < IVL);
    waitN;
    chk("nextGap", IVL, gap);
    wr(CMD_RATE_WR, 8'h07);
    rd(CMD_RATE_RD);
    chk("rate", 8'h07, d);
    n0 = nStart;
    waitN;
    waitN;
    chk("rateGap", 2 * IVL, gap);
    print_verdict;
  end
endmodule : tb_top
